// file: hw/fps_pkg.sv
// Purpose: Constants, register map and state type for the flash program/erase sequencer.
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register.
// Notes:
// Functional notes
// - Erase-arming write in protected range erases nothing.
// - Row is 64 aligned bytes inside 128-byte block.
// - Writes outside the latched row fail programming.
// - Program select enables latching of array writes.
// - Wait mode suspends sequences into standby only.
// - Stop mode suspends sequences into standby only.
// - Standby holds all array controls inactive.
// - Erase and program selects are mutually interlocked.
// - High voltage only after select and proper steps.
// - Protected target refuses high voltage enable.
// - Protect value gives address bits 14..7, bit15 set.
package fps_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ROW_AW = 6;
  localparam int unsigned ROW_BYTES = 64;

  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PROTECT = 8'h04;
  localparam logic [7:0] OFS_ARRAY   = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;

  localparam int unsigned CTRL_PGM   = 0;
  localparam int unsigned CTRL_ERASE = 1;
  localparam int unsigned CTRL_WHOLE = 2;
  localparam int unsigned CTRL_HV    = 3;

  localparam int unsigned ARR_DATA_LSB = 0;
  localparam int unsigned ARR_ADDR_LSB = 8;

  localparam int unsigned ST_ROW_FAIL  = 0;
  localparam int unsigned ST_REFUSED   = 1;
  localparam int unsigned ST_STANDBY   = 2;
  localparam int unsigned ST_STATE_LSB = 4;
  localparam int unsigned ST_LATCH_LSB = 16;

  localparam logic [7:0]  PROTECT_RST  = 8'hff;
  localparam logic [7:0]  PROTECT_NONE = 8'hff;
  localparam logic [15:0] ARRAY_BASE   = 16'h8000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [2:0] {
    FPS_IDLE,
    FPS_SELECTED,
    FPS_PROT_READ,
    FPS_LATCHED,
    FPS_HV_ON
  } fps_state_t;

endpackage

// file: hw/fps_row_buf.sv
// Purpose: 64-byte row buffer holding the bytes latched during programming.
// Assumes: One write port, one read port; read data comes from a register.
// Notes: Storage is not reset; only the read register is.
`timescale 1ns/1ns
`default_nettype none
module fps_row_buf
  import fps_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 we,
  input  wire logic [ROW_AW-1:0]    waddr,
  input  wire logic [DATA_W-1:0]    wdata,
  input  wire logic [ROW_AW-1:0]    raddr,
  output logic      [DATA_W-1:0]    rdata
);
  import fps_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] rd;
  } fps_rb_t;

  logic [DATA_W-1:0] mem [ROW_BYTES];
  fps_rb_t           st_ff;
  fps_rb_t           nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.rd = mem[raddr];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = st_ff.rd;
endmodule
`default_nettype wire

// file: hw/fps_sequencer.sv
// Purpose: Program/erase sequencer for the flash array with an AXI4-Lite register slave.
// Assumes: Single clock; wait and stop requests are synchronous levels.
// Notes: Timing windows are software's job; hardware enforces order, protection and rows.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fps_sequencer
  import fps_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 wait_mode,
  input  wire logic                 stop_mode,
  output logic                      arr_erase,
  output logic                      arr_whole,
  output logic                      arr_program,
  output logic                      arr_high_voltage,
  output logic [ADDR_W-1:0]         arr_addr,
  output logic [DATA_W-1:0]         arr_data,
  output logic                      arr_write,
  output logic                      arr_standby
);
  import fps_pkg::*;

  typedef struct packed {
    logic              aw_got;
    logic [7:0]        aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              program_select;
    logic              erase;
    logic              whole;
    logic              hv;
    logic [7:0]        protect;
    fps_state_t        state;
    logic [ADDR_W-1:0] latch_addr;
    logic              row_fail;
    logic              refused;
    logic              standby;
    logic              o_erase;
    logic              o_whole;
    logic              o_pgm;
    logic              o_hv;
    logic [ADDR_W-1:0] o_addr;
    logic              o_write;
    logic              buf_pend;
  } fps_st_t;

  fps_st_t st_ff;
  fps_st_t nxt_st;

  logic              buf_we;
  logic [ROW_AW-1:0] buf_waddr;
  logic [DATA_W-1:0] buf_wdata;
  logic [DATA_W-1:0] buf_rdata;

  // Protected range starts at {1, protect, 0000000} and runs to the top
  function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [7:0] p);
    logic [ADDR_W-1:0] start;
    start = {1'b1, p, 7'h00};
    return (p != PROTECT_NONE) && (a >= start);
  endfunction

  function automatic logic same_row(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return a[ADDR_W-1:ROW_AW] == b[ADDR_W-1:ROW_AW];
  endfunction

  always_comb begin
    logic              wr_fire;
    logic              rd_fire;
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic              arr_wr_ok;
    logic              want_pgm;
    logic              want_erase;
    logic              in_seq;
    logic              row_fail_set;
    logic              refused_set;
    wr_fire      = 1'b0;
    rd_fire      = 1'b0;
    wa           = st_ff.w_data[ARR_ADDR_LSB +: ADDR_W];
    wd           = st_ff.w_data[ARR_DATA_LSB +: DATA_W];
    arr_wr_ok    = 1'b0;
    want_pgm     = 1'b0;
    want_erase   = 1'b0;
    in_seq       = 1'b0;
    row_fail_set = 1'b0;
    refused_set  = 1'b0;
    buf_we       = 1'b0;
    buf_waddr    = wa[ROW_AW-1:0];
    buf_wdata    = wd;
    nxt_st       = st_ff;
    nxt_st.o_write = 1'b0;

    // Write channel: address and data taken in either order, response after both
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      wr_fire       = 1'b1;
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = RESP_OKAY;
    end
    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;

    if (wr_fire) begin
      case (st_ff.aw_addr)
        OFS_CTRL: begin
          if (st_ff.w_strb[0]) begin
            want_pgm   = st_ff.w_data[CTRL_PGM];
            want_erase = st_ff.w_data[CTRL_ERASE];
            // Neither select may be raised while the other is held or requested
            if (want_pgm && !st_ff.erase && !want_erase) begin
              nxt_st.program_select = 1'b1;
            end else if (!want_pgm) begin
              nxt_st.program_select = 1'b0;
            end
            if (want_erase && !st_ff.program_select && !want_pgm) begin
              nxt_st.erase = 1'b1;
            end else if (!want_erase) begin
              nxt_st.erase = 1'b0;
            end
            nxt_st.whole = st_ff.w_data[CTRL_WHOLE];
            if (!st_ff.w_data[CTRL_HV]) begin
              nxt_st.hv = 1'b0;
            end else if (!st_ff.hv) begin
              // Voltage only after select, protect read and the arming write
              if (st_ff.state == FPS_LATCHED && (st_ff.program_select || st_ff.erase)) begin
                if (is_protected(st_ff.latch_addr, st_ff.protect)) begin
                  refused_set = 1'b1;
                end else begin
                  nxt_st.hv    = 1'b1;
                  nxt_st.state = FPS_HV_ON;
                end
              end
            end
            // Selecting a mode from idle starts the arming order
            if (st_ff.state == FPS_IDLE && (nxt_st.program_select || nxt_st.erase)) begin
              nxt_st.state = FPS_SELECTED;
            end
          end else begin
            nxt_st.bresp = RESP_OKAY;
          end
        end
        OFS_PROTECT: begin
          if (st_ff.w_strb[0] && st_ff.state == FPS_IDLE) begin
            nxt_st.protect = st_ff.w_data[7:0];
          end
        end
        OFS_ARRAY: begin
          arr_wr_ok = (&st_ff.w_strb[2:0]) && (wa >= ARRAY_BASE);
          if (arr_wr_ok) begin
            if (st_ff.state == FPS_PROT_READ) begin
              nxt_st.latch_addr = wa;
              nxt_st.state      = FPS_LATCHED;
              if (is_protected(wa, st_ff.protect)) begin
                refused_set = 1'b1;
              end
            end else if (st_ff.state == FPS_HV_ON && st_ff.program_select) begin
              if (same_row(wa, st_ff.latch_addr)) begin
                buf_we          = 1'b1;
                nxt_st.o_addr   = wa;
                nxt_st.buf_pend = 1'b1;
              end else begin
                row_fail_set = 1'b1;
              end
            end
          end
        end
        OFS_STATUS: begin
          if (st_ff.w_strb[0]) begin
            if (st_ff.w_data[ST_ROW_FAIL]) begin
              nxt_st.row_fail = 1'b0;
            end
            if (st_ff.w_data[ST_REFUSED]) begin
              nxt_st.refused = 1'b0;
            end
          end
        end
        default: begin
          nxt_st.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Hardware set wins over a software clear in the same cycle
    if (row_fail_set) begin
      nxt_st.row_fail = 1'b1;
    end
    if (refused_set) begin
      nxt_st.refused = 1'b1;
    end

    // A sequence ends once both selects and the voltage are down
    if (nxt_st.state != FPS_IDLE && !nxt_st.program_select && !nxt_st.erase && !nxt_st.hv) begin
      nxt_st.state = FPS_IDLE;
    end

    // Read channel: one read in flight, answer the cycle after acceptance
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      rd_fire       = 1'b1;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      nxt_st.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        OFS_CTRL: begin
          nxt_st.rdata[CTRL_PGM]   = st_ff.program_select;
          nxt_st.rdata[CTRL_ERASE] = st_ff.erase;
          nxt_st.rdata[CTRL_WHOLE] = st_ff.whole;
          nxt_st.rdata[CTRL_HV]    = st_ff.hv;
        end
        OFS_PROTECT: begin
          nxt_st.rdata[7:0] = st_ff.protect;
          // The protect read is the second arming step
          if (st_ff.state == FPS_SELECTED) begin
            nxt_st.state = FPS_PROT_READ;
          end
        end
        OFS_STATUS: begin
          nxt_st.rdata[ST_ROW_FAIL]            = st_ff.row_fail;
          nxt_st.rdata[ST_REFUSED]             = st_ff.refused;
          nxt_st.rdata[ST_STANDBY]             = st_ff.standby;
          nxt_st.rdata[ST_STATE_LSB +: 3]      = st_ff.state;
          nxt_st.rdata[ST_LATCH_LSB +: ADDR_W] = st_ff.latch_addr;
        end
        OFS_ARRAY: begin
          nxt_st.rdata = 32'h0000_0000;
        end
        default: begin
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_st.arready = !nxt_st.rvalid && !rd_fire;

    // Low-power request suspends only an active sequence; read mode is untouched
    in_seq         = (st_ff.state != FPS_IDLE);
    nxt_st.standby = (wait_mode || stop_mode) && in_seq;

    // The buffered byte is presented once its registered read data is valid
    if (st_ff.buf_pend) begin
      nxt_st.buf_pend = 1'b0;
      nxt_st.o_write  = !nxt_st.standby;
    end

    // Array controls, all forced inactive in standby
    if (nxt_st.standby) begin
      nxt_st.o_erase = 1'b0;
      nxt_st.o_whole = 1'b0;
      nxt_st.o_pgm   = 1'b0;
      nxt_st.o_hv    = 1'b0;
      nxt_st.o_write = 1'b0;
    end else begin
      nxt_st.o_erase = nxt_st.erase;
      nxt_st.o_whole = nxt_st.whole && nxt_st.erase;
      nxt_st.o_pgm   = nxt_st.program_select;
      nxt_st.o_hv    = nxt_st.hv;
      if (nxt_st.state == FPS_LATCHED && st_ff.state != FPS_LATCHED) begin
        nxt_st.o_addr = nxt_st.latch_addr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff         <= '0;
      st_ff.protect <= PROTECT_RST;
      st_ff.state   <= FPS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  fps_row_buf u_row_buf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (buf_we),
    .waddr   (buf_waddr),
    .wdata   (buf_wdata),
    .raddr   (st_ff.o_addr[ROW_AW-1:0]),
    .rdata   (buf_rdata)
  );

  assign s_axi_awready    = st_ff.awready;
  assign s_axi_wready     = st_ff.wready;
  assign s_axi_bvalid     = st_ff.bvalid;
  assign s_axi_bresp      = st_ff.bresp;
  assign s_axi_arready    = st_ff.arready;
  assign s_axi_rvalid     = st_ff.rvalid;
  assign s_axi_rdata      = st_ff.rdata;
  assign s_axi_rresp      = st_ff.rresp;
  assign arr_erase        = st_ff.o_erase;
  assign arr_whole        = st_ff.o_whole;
  assign arr_program      = st_ff.o_pgm;
  assign arr_high_voltage = st_ff.o_hv;
  assign arr_addr         = st_ff.o_addr;
  assign arr_data         = buf_rdata;
  assign arr_write        = st_ff.o_write;
  assign arr_standby      = st_ff.standby;
endmodule
`default_nettype wire

// file: bench/fps_sequencer_sva.sv
// Purpose: Concurrent checks on the array control outputs of the sequencer.
// Assumes: Single clock domain, synchronous active-low reset.
// Notes: Sees only top-level ports; attached by bind at the foot.
`timescale 1ns/1ns
`default_nettype none
module fps_sequencer_sva
  import fps_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              wait_mode,
  input wire logic              stop_mode,
  input wire logic              arr_erase,
  input wire logic              arr_whole,
  input wire logic              arr_program,
  input wire logic              arr_high_voltage,
  input wire logic [ADDR_W-1:0] arr_addr,
  input wire logic              arr_write,
  input wire logic              arr_standby
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_INTERLOCK: assert property (!(arr_erase && arr_program)) else $error("erase and program both set");
  AST_HV_RISE: assert property ($rose(arr_high_voltage) |-> (arr_erase || arr_program))
    else $error("high voltage rose without a select");
  AST_STANDBY_QUIET: assert property (arr_standby |-> !(arr_erase || arr_whole || arr_program ||
    arr_high_voltage || arr_write)) else $error("array control active in standby");
  AST_STANDBY_CAUSE: assert property ($rose(arr_standby) |-> $past(wait_mode || stop_mode))
    else $error("standby entered without a low-power request");
  AST_STANDBY_ENTRY: assert property ((wait_mode || stop_mode) && (arr_erase || arr_program) |=> arr_standby)
    else $error("low-power request did not suspend the sequence");
  AST_WRITE_QUAL: assert property (arr_write |-> arr_program && arr_high_voltage)
    else $error("byte write outside an armed program sequence");
  AST_WRITE_PULSE: assert property (arr_write |=> !arr_write) else $error("byte write pulse too long");
  AST_ROW_HELD: assert property (arr_high_voltage && $past(arr_high_voltage) && arr_program &&
    !arr_standby && !$past(arr_standby) |-> arr_addr[15:6] == $past(arr_addr[15:6]))
    else $error("target row changed during programming");
  AST_WHOLE_ERASE: assert property (arr_whole |-> arr_erase) else $error("whole select without erase");

  COV_BYTE: cover property (arr_write);
  COV_HV: cover property ($rose(arr_high_voltage));
  COV_STANDBY: cover property ($rose(arr_standby));
endmodule

bind fps_sequencer fps_sequencer_sva i_sva (
  .aclk             (aclk),
  .aresetn          (aresetn),
  .wait_mode        (wait_mode),
  .stop_mode        (stop_mode),
  .arr_erase        (arr_erase),
  .arr_whole        (arr_whole),
  .arr_program      (arr_program),
  .arr_high_voltage (arr_high_voltage),
  .arr_addr         (arr_addr),
  .arr_write        (arr_write),
  .arr_standby      (arr_standby)
);
`default_nettype wire

// file: bench/fps_array_model.sv
// Purpose: Behavioural flash array on the far side of the control outputs.
// Assumes: A byte is programmed on each cycle that arr_write is high.
// Notes: Counts byte writes made without an armed program sequence.
`timescale 1ns/1ns
`default_nettype none
module fps_array_model
  import fps_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              arr_program,
  input  wire logic              arr_high_voltage,
  input  wire logic [ADDR_W-1:0] arr_addr,
  input  wire logic [DATA_W-1:0] arr_data,
  input  wire logic              arr_write,
  output logic      [ADDR_W-1:0] last_addr,
  output logic      [DATA_W-1:0] last_data,
  output logic      [7:0]        write_count,
  output logic      [7:0]        bad_count
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_addr   <= '0;
      last_data   <= '0;
      write_count <= '0;
      bad_count   <= '0;
    end else if (arr_write) begin
      last_addr   <= arr_addr;
      last_data   <= arr_data;
      write_count <= write_count + 8'h01;
      // A cell only programs under high voltage with program selected
      if (!(arr_program && arr_high_voltage)) bad_count <= bad_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: bench/fps_sequencer_test.sv
// Purpose: Self-checking bench for the program/erase sequencer.
// Assumes: AXI4-Lite master tasks; array model on the control outputs.
// Notes: Register table first, then protection, erase, program and low-power cases.
`timescale 1ns/1ns
`default_nettype none
module fps_sequencer_test;
  import fps_pkg::*;
  typedef struct packed {
    logic        we;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
    logic [1:0]  r;
  } fps_row_t;

  logic        aclk, aresetn, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, wait_mode, stop_mode;
  logic [7:0]  awa, ara, cnt, bad;
  logic [31:0] wd, rd_data;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp;
  logic        er, wh, pg, hv, aw, sb;
  logic [15:0] aa, la;
  logic [7:0]  ad, ld;
  int          mismatches, tests_run, cycles;
  fps_row_t    rows [9];
  logic [15:0] offs [3];
  logic [31:0] v;
  logic [1:0]  r;

  fps_sequencer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_data), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .wait_mode(wait_mode), .stop_mode(stop_mode), .arr_erase(er), .arr_whole(wh),
    .arr_program(pg), .arr_high_voltage(hv), .arr_addr(aa), .arr_data(ad), .arr_write(aw),
    .arr_standby(sb));
  fps_array_model i_model (.aclk(aclk), .aresetn(aresetn), .arr_program(pg), .arr_high_voltage(hv),
    .arr_addr(aa), .arr_data(ad), .arr_write(aw), .last_addr(la), .last_data(ld), .write_count(cnt),
    .bad_count(bad));

  always #10 aclk = ~aclk;

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // The ceiling sits far above the expected run length
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Handshakes are judged mid-cycle, where the registered readies have settled,
  // so each channel is released just after the edge that took it
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic t_aw, t_w, t_b, done;
    done = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    ws  <= 4'hf;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      t_aw = awv && (awr === 1'b1);
      t_w  = wv && (wr_rdy === 1'b1);
      t_b  = (bv === 1'b1);
      if (t_b) resp = bresp;
      @(posedge aclk);
      if (t_aw) awv <= 1'b0;
      if (t_w) wv <= 1'b0;
      if (t_b) begin
        br   <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic t_ar, t_r, done;
    done = 1'b0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      t_ar = arv && (arr === 1'b1);
      t_r  = (rv === 1'b1);
      if (t_r) begin
        d    = rd_data;
        resp = rresp;
      end
      @(posedge aclk);
      if (t_ar) arv <= 1'b0;
      if (t_r) begin
        rr   <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_read(a, v, r);
    chk(v & m, e);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  // Outputs are compared mid-cycle; the next stimulus waits for a rising edge
  task automatic settle();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  initial begin
    aclk = 0; aresetn = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; wait_mode = 0; stop_mode = 0;
    awa = '0; ara = '0; wd = '0; ws = '0; cycles = 0; mismatches = 0; tests_run = 0;
    rows = '{'{1'b0, OFS_PROTECT, 32'h0, 32'hff, 32'hff, RESP_OKAY},
             '{1'b0, OFS_CTRL, 32'h0, 32'hf, 32'h0, RESP_OKAY},
             '{1'b0, OFS_STATUS, 32'h0, 32'hffffffff, 32'h0, RESP_OKAY},
             '{1'b1, 8'h10, 32'h1, 32'h0, 32'h0, RESP_SLVERR},
             '{1'b0, 8'h10, 32'h0, 32'h0, 32'h0, RESP_SLVERR},
             '{1'b1, OFS_CTRL, 32'h3, 32'h0, 32'h0, RESP_OKAY},
             '{1'b0, OFS_CTRL, 32'h0, 32'hf, 32'h0, RESP_OKAY},
             '{1'b1, OFS_CTRL, 32'h8, 32'h0, 32'h0, RESP_OKAY},
             '{1'b0, OFS_CTRL, 32'h0, 32'hf, 32'h0, RESP_OKAY}};
    offs = '{16'h0000, 16'h001f, 16'h003f};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Stimulus stands for code outside the array with interrupts masked
    foreach (rows[i]) begin
      if (rows[i].we) axi_write(rows[i].a, rows[i].d, r);
      else axi_read(rows[i].a, v, r);
      if (!rows[i].we) chk(v & rows[i].m, rows[i].e);
      chk({30'h0, r}, {30'h0, rows[i].r});
    end
    // Protected page: arming still latches, high voltage refused
    wr(OFS_PROTECT, 32'hfe);
    wr(OFS_CTRL, 32'h2);
    rd(OFS_PROTECT, 32'hff, 32'hfe);
    wr(OFS_ARRAY, {8'h0, 16'hff10, 8'h00});
    wr(OFS_CTRL, 32'ha);
    rd(OFS_CTRL, 32'hf, 32'h2);
    rd(OFS_STATUS, 32'hffff0002, 32'hff100002);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_STATUS, 32'h3);
    // Whole erase, suspended by wait mode and resumed; array untouched between steps
    wr(OFS_CTRL, 32'h6);
    rd(OFS_PROTECT, 32'hff, 32'hfe);
    wr(OFS_ARRAY, {8'h0, 16'h8000, 8'h5a});
    wr(OFS_CTRL, 32'he);
    settle();
    chk({28'h0, er, wh, pg, hv}, 32'hd);
    @(posedge aclk);
    wait_mode <= 1'b1;
    settle();
    chk({28'h0, sb, er, wh, hv}, 32'h8);
    rd(OFS_STATUS, 32'h74, 32'h44);
    @(posedge aclk);
    wait_mode <= 1'b0;
    settle();
    chk({28'h0, sb, er, wh, hv}, 32'h7);
    wr(OFS_CTRL, 32'h8);
    wr(OFS_CTRL, 32'h0);
    settle();
    chk({31'h0, hv}, 32'h0);
    // Protect register never read: high voltage must stay off
    wr(OFS_CTRL, 32'h2);
    wr(OFS_ARRAY, {8'h0, 16'h8080, 8'h00});
    wr(OFS_CTRL, 32'ha);
    settle();
    chk({31'h0, hv}, 32'h0);
    wr(OFS_CTRL, 32'h0);
    // Page erase of the page that holds the row programmed next
    wr(OFS_CTRL, 32'h2);
    rd(OFS_PROTECT, 32'hff, 32'hfe);
    wr(OFS_ARRAY, {8'h0, 16'h8100, 8'h00});
    wr(OFS_CTRL, 32'ha);
    settle();
    chk({29'h0, er, wh, hv}, 32'h5);
    wr(OFS_CTRL, 32'h8);
    wr(OFS_CTRL, 32'h0);
    settle();
    chk({29'h0, er, wh, hv}, 32'h0);
    // Row program at both row edges, then a byte from the next row
    wr(OFS_CTRL, 32'h1);
    rd(OFS_PROTECT, 32'hff, 32'hfe);
    wr(OFS_ARRAY, {8'h0, 16'h8140, 8'h00});
    wr(OFS_CTRL, 32'h9);
    settle();
    chk({30'h0, pg, hv}, 32'h3);
    foreach (offs[i]) begin
      wr(OFS_ARRAY, {8'h0, 16'h8140 + offs[i], 8'h30 + 8'(i)});
      settle();
      chk({16'h0, la}, {16'h0, 16'h8140 + offs[i]});
      chk({24'h0, ld}, {24'h0, 8'h30 + 8'(i)});
    end
    wr(OFS_ARRAY, {8'h0, 16'h8180, 8'h77});
    settle();
    chk({24'h0, cnt}, 32'h3);
    rd(OFS_STATUS, 32'h1, 32'h1);
    @(posedge aclk);
    stop_mode <= 1'b1;
    settle();
    chk({28'h0, sb, pg, hv, aw}, 32'h8);
    @(posedge aclk);
    stop_mode <= 1'b0;
    settle();
    chk({30'h0, pg, hv}, 32'h3);
    wr(OFS_CTRL, 32'h8);
    wr(OFS_CTRL, 32'h0);
    settle();
    chk({31'h0, hv}, 32'h0);
    chk({24'h0, bad}, 32'h0);
    // Reset in mid-sequence drops every control and restores the protect value
    wr(OFS_CTRL, 32'h1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({26'h0, er, wh, pg, hv, aw, sb}, 32'h0);
    rd(OFS_PROTECT, 32'hff, 32'hff);
    rd(OFS_CTRL, 32'hf, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
